//--- core/rpl_status_regs.sv
`timescale 1ns/1ns
module rpl_status_regs
   import rpl_pkg::*;
#(
   parameter int NUM_PORTS = 2,
   parameter int CNT_W     = 16
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire rpl_req_t                 req,
   output logic [7:0]                    rdata_q,
   output logic                          rvalid_q,
   input  wire rpl_rx_t [NUM_PORTS-1:0]  rx,
   input  wire logic [CNT_W-1:0]         parity_count_threshold,
   output logic [NUM_PORTS-1:0]          parity_flag
);

   localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

   ////////////////////////////////////////////////////////////////////////////
   // Port select and access decode

   logic [7:0]             port_sel_q;
   logic [7:0]             port_sel_d;
   logic [PW-1:0]          cur_port;
   logic [NUM_PORTS-1:0]   rd_lower;
   logic [7:0]             upper_snap_q;
   logic [7:0]             upper_snap_d;
   logic                   snap_ok_q;
   logic                   snap_ok_d;

   // Port select: one bit per port; reads and the lower-byte clear use the lowest set bit
   function automatic logic [PW-1:0] first_port(input logic [7:0] sel);
      logic [PW-1:0] p;
      p = '0;
      for (int i = NUM_PORTS - 1; i >= 0; i--) begin
         if (sel[i]) begin
            p = PW'(i);
         end
      end
      return p;
   endfunction : first_port

   assign cur_port = first_port(port_sel_q);

   always_comb begin
      port_sel_d = port_sel_q;
      if (req.wr && req.addr == RPL_OFS_PORT_SEL) begin
         port_sel_d = req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-port copies

   logic [7:0]        freq_int   [NUM_PORTS];
   logic [7:0]        freq_frac  [NUM_PORTS];
   rpl_sensor_t       sensor     [NUM_PORTS];
   logic [CNT_W-1:0]  count      [NUM_PORTS];

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : g_port
         // Lower byte read clears only the selected port's counter
         assign rd_lower[g] = req.rd && req.addr == RPL_OFS_PAR_LOWER
                              && PW'(g) == cur_port;
         rpl_port_status #(
            .CNT_W (CNT_W)
         ) u_port (
            .ref_clk       (ref_clk),
            .rst           (rst),
            .rx            (rx[g]),
            .rd_lower      (rd_lower[g]),
            .threshold     (parity_count_threshold),
            .freq_int_q    (freq_int[g]),
            .freq_frac_q   (freq_frac[g]),
            .sensor_q      (sensor[g]),
            .count_q       (count[g]),
            .parity_flag_q (parity_flag[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   logic [7:0]  rdata_d;
   logic        rvalid_d;
   rpl_sensor_t s;
   logic [15:0] cnt16;

   always_comb begin
      s            = sensor[cur_port];
      cnt16        = 16'(count[cur_port]);
      rdata_d      = RPL_RST_BYTE;
      rvalid_d     = req.rd;
      upper_snap_d = upper_snap_q;
      snap_ok_d    = snap_ok_q;
      unique case (req.addr)
         RPL_OFS_PORT_SEL:  rdata_d = port_sel_q;
         RPL_OFS_FREQ_INT:  rdata_d = freq_int[cur_port];
         RPL_OFS_FREQ_FRAC: rdata_d = freq_frac[cur_port];
         RPL_OFS_ALARM: begin
            rdata_d[RPL_ALARM_W-1:0] = s.alarm;
         end
         RPL_OFS_VOLT: begin
            rdata_d[RPL_VOLT_B_LSB +: RPL_LEVEL_W] = s.remote_voltage_b_level;
            rdata_d[RPL_VOLT_A_LSB +: RPL_LEVEL_W] = s.remote_voltage_a_level;
         end
         RPL_OFS_TEMP: begin
            rdata_d[RPL_LEVEL_W-1:0] = s.temp_level;
         end
         RPL_OFS_CSI: begin
            rdata_d[RPL_CSI_FLAGS_W-1:0] = s.csi_flags;
         end
         RPL_OFS_PAR_UPPER: begin
            // Snapshot the low byte so a following lower read matches this upper
            rdata_d = cnt16[15:8];
            if (req.rd) begin
               upper_snap_d = cnt16[7:0];
               snap_ok_d    = 1'b1;
            end
         end
         RPL_OFS_PAR_LOWER: begin
            rdata_d = snap_ok_q ? upper_snap_q : cnt16[7:0];
            if (req.rd) begin
               snap_ok_d = 1'b0;
            end
         end
         default: rdata_d = RPL_RST_BYTE;
      endcase
      if (req.wr && req.addr == RPL_OFS_PORT_SEL) begin
         snap_ok_d = 1'b0;
      end
      if (!req.rd) begin
         rdata_d = rdata_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         port_sel_q   <= RPL_RST_PSEL;
         rdata_q      <= RPL_RST_BYTE;
         rvalid_q     <= 1'b0;
         upper_snap_q <= RPL_RST_BYTE;
         snap_ok_q    <= 1'b0;
      end else begin
         port_sel_q   <= port_sel_d;
         rdata_q      <= rdata_d;
         rvalid_q     <= rvalid_d;
         upper_snap_q <= upper_snap_d;
         snap_ok_q    <= snap_ok_d;
      end
   end

endmodule : rpl_status_regs

//--- common/rpl_pkg.sv
package rpl_pkg;

   // Register offsets on the local register port
   localparam logic [7:0] RPL_OFS_PORT_SEL   = 8'h4c;
   localparam logic [7:0] RPL_OFS_FREQ_INT   = 8'h4f;
   localparam logic [7:0] RPL_OFS_FREQ_FRAC  = 8'h50;
   localparam logic [7:0] RPL_OFS_ALARM      = 8'h51;
   localparam logic [7:0] RPL_OFS_VOLT       = 8'h52;
   localparam logic [7:0] RPL_OFS_TEMP       = 8'h53;
   localparam logic [7:0] RPL_OFS_CSI        = 8'h54;
   localparam logic [7:0] RPL_OFS_PAR_UPPER  = 8'h55;
   localparam logic [7:0] RPL_OFS_PAR_LOWER  = 8'h56;

   // Field positions
   localparam int RPL_ALARM_CSI_BIT    = 5;
   localparam int RPL_ALARM_BCC_BIT    = 4;
   localparam int RPL_ALARM_LINK_BIT   = 3;
   localparam int RPL_ALARM_TEMP_BIT   = 2;
   localparam int RPL_ALARM_VB_BIT     = 1;
   localparam int RPL_ALARM_VA_BIT     = 0;
   localparam int RPL_VOLT_B_LSB       = 4;
   localparam int RPL_VOLT_A_LSB       = 0;
   localparam int RPL_LEVEL_W          = 3;
   localparam int RPL_CSI_FLAGS_W      = 5;
   localparam int RPL_ALARM_W          = 6;

   // Reset values
   localparam logic [7:0]  RPL_RST_BYTE  = 8'h00;
   localparam logic [15:0] RPL_RST_COUNT = 16'h0000;
   localparam logic [7:0]  RPL_RST_PSEL  = 8'h01;

   // Status carried by the forward channel from the remote serializer
   typedef struct packed {
      logic [RPL_ALARM_W-1:0]     alarm;
      logic [RPL_LEVEL_W-1:0]     remote_voltage_b_level;
      logic [RPL_LEVEL_W-1:0]     remote_voltage_a_level;
      logic [RPL_LEVEL_W-1:0]     temp_level;
      logic [RPL_CSI_FLAGS_W-1:0] csi_flags;
   } rpl_sensor_t;

   // Per-port receiver measurements and events
   typedef struct packed {
      logic [7:0]  rx_freq_mhz_int;
      logic [7:0]  rx_freq_mhz_frac;
      logic        freq_valid;
      logic        sensor_valid;
      rpl_sensor_t sensor;
      logic        parity_err;
      logic        lock_acquired;
   } rpl_rx_t;

   // Register port request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rpl_req_t;

endpackage : rpl_pkg

//--- core/rpl_port_status.sv
`timescale 1ns/1ns
// One receive port's copy of the status registers
module rpl_port_status
   import rpl_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire rpl_rx_t          rx,
   input  wire logic             rd_lower,
   input  wire logic [CNT_W-1:0] threshold,
   output logic [7:0]            freq_int_q,
   output logic [7:0]            freq_frac_q,
   output rpl_sensor_t           sensor_q,
   output logic [CNT_W-1:0]      count_q,
   output logic                  parity_flag_q
);

   logic [7:0]       freq_int_d;
   logic [7:0]       freq_frac_d;
   rpl_sensor_t      sensor_d;
   logic [CNT_W-1:0] count_d;
   logic             parity_flag_d;

   always_comb begin
      freq_int_d    = freq_int_q;
      freq_frac_d   = freq_frac_q;
      sensor_d      = sensor_q;
      count_d       = count_q;
      parity_flag_d = parity_flag_q;
      if (rx.freq_valid) begin
         freq_int_d  = rx.rx_freq_mhz_int;
         freq_frac_d = rx.rx_freq_mhz_frac;
      end
      // Only the forward channel loads these, never the host
      if (rx.sensor_valid) begin
         sensor_d = rx.sensor;
      end
      // A lock or a lower-byte read restarts the count; an error in the same
      // cycle counts as the first of the new run so it is not lost
      if (rx.lock_acquired || rd_lower) begin
         count_d = rx.parity_err ? CNT_W'(1) : '0;
      end else if (rx.parity_err && count_q != '1) begin
         count_d = count_q + CNT_W'(1);
      end
      if (count_d > threshold) begin
         parity_flag_d = 1'b1;
      end else if (rx.lock_acquired || rd_lower) begin
         parity_flag_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         freq_int_q    <= RPL_RST_BYTE;
         freq_frac_q   <= RPL_RST_BYTE;
         sensor_q      <= '0;
         count_q       <= CNT_W'(RPL_RST_COUNT);
         parity_flag_q <= 1'b0;
      end else begin
         freq_int_q    <= freq_int_d;
         freq_frac_q   <= freq_frac_d;
         sensor_q      <= sensor_d;
         count_q       <= count_d;
         parity_flag_q <= parity_flag_d;
      end
   end

endmodule : rpl_port_status

//--- dv/rpl_status_regs_properties.sv
`timescale 1ns/1ns
module rpl_status_regs_properties
   import rpl_pkg::*;
#(
   parameter int NUM_PORTS = 2,
   parameter int CNT_W     = 16
) (
   input wire logic                    ref_clk,
   input wire logic                    rst,
   input wire rpl_req_t                req,
   input wire logic [7:0]              rdata_q,
   input wire logic                    rvalid_q,
   input wire rpl_rx_t [NUM_PORTS-1:0] rx,
   input wire logic [CNT_W-1:0]        parity_count_threshold,
   input wire logic [NUM_PORTS-1:0]    parity_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   read_answer_a: assert property (req.rd |=> rvalid_q)
      else $error("read gave no answer");
   idle_quiet_a: assert property (!req.rd |=> !rvalid_q && $stable(rdata_q))
      else $error("answer without a read");
   unmapped_zero_a: assert property (req.rd && req.addr == 8'h4d |=> rdata_q == 8'h00)
      else $error("unmapped read not zero");
   alarm_rsvd_a: assert property (req.rd && req.addr == RPL_OFS_ALARM
      |=> rdata_q[7:6] == 2'h0)
      else $error("alarm reserved bits set");
   volt_rsvd_a: assert property (req.rd && req.addr == RPL_OFS_VOLT
      |=> !rdata_q[7] && !rdata_q[3])
      else $error("voltage reserved bits set");
   temp_rsvd_a: assert property (req.rd && req.addr == RPL_OFS_TEMP
      |=> rdata_q[7:3] == 5'h00)
      else $error("temperature reserved bits set");
   csi_rsvd_a: assert property (req.rd && req.addr == RPL_OFS_CSI |=> rdata_q[7:5] == 3'h0)
      else $error("csi reserved bits set");
   // A lowered threshold may legitimately raise the flag with no new error
   flag_cause_a: assert property ($rose(parity_flag[0]) |->
      $past(rx[0].parity_err)
      || $past(parity_count_threshold) < $past(parity_count_threshold, 2))
      else $error("parity flag rose without an error");
   lock_clear_a: assert property (rx[0].lock_acquired && !rx[0].parity_err |=> !parity_flag[0])
      else $error("parity flag kept over new lock");
   cover property (req.rd && req.addr == RPL_OFS_PAR_LOWER);
   cover property ($rose(parity_flag[0]));
   cover property (rx[0].lock_acquired);
endmodule : rpl_status_regs_properties

bind rpl_status_regs rpl_status_regs_properties #(.NUM_PORTS(NUM_PORTS), .CNT_W(CNT_W)) u_props (
   .ref_clk(ref_clk), .rst(rst), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .rx(rx),
   .parity_count_threshold(parity_count_threshold), .parity_flag(parity_flag));

//--- dv/rpl_serializer_model.sv
`timescale 1ns/1ns
// Far-end status source; pulses exist only while go is high and repeat on every cycle that go stays high
module rpl_serializer_model
   import rpl_pkg::*;
(
   input wire logic    go,
   input wire logic    port,
   input wire rpl_rx_t val,
   output rpl_rx_t [1:0] rx
);
   assign rx[0] = (go && !port) ? val : '0;
   assign rx[1] = (go && port) ? val : '0;
endmodule : rpl_serializer_model

//--- dv/rpl_status_regs_tb.sv
`timescale 1ns/1ns
module rpl_status_regs_tb
   import rpl_pkg::*;
;
   typedef struct packed {logic [7:0] psel; logic [7:0] addr; logic [7:0] exp;} rpl_row_t;
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   rpl_req_t      req = '0;
   logic [7:0]    rdata_q;
   logic          rvalid_q;
   rpl_rx_t [1:0] rx;
   logic [1:0]    parity_flag;
   logic [15:0]   count_threshold = 16'h0003;
   logic          go = 1'b0;
   logic          port = 1'b0;
   rpl_rx_t       val = '0;
   rpl_rx_t       s0, s1, e, lk;
   int            mismatches = 0;
   int            samples_checked = 0;
   rpl_row_t rows [15] = '{'{8'h01, 8'h4f, 8'h93}, '{8'h01, 8'h50, 8'h40}, '{8'h01, 8'h51, 8'h2a},
      '{8'h01, 8'h52, 8'h53}, '{8'h01, 8'h53, 8'h06}, '{8'h01, 8'h54, 8'h15}, '{8'h02, 8'h4f, 8'h2c},
      '{8'h02, 8'h50, 8'hc1}, '{8'h02, 8'h51, 8'h15}, '{8'h02, 8'h52, 8'h24}, '{8'h02, 8'h53, 8'h01},
      '{8'h02, 8'h54, 8'h0a}, '{8'h02, 8'h4c, 8'h02}, '{8'h02, 8'h4d, 8'h00},
      '{8'h03, 8'h4f, 8'h93}};
   always #4 ref_clk = ~ref_clk;
   rpl_status_regs u_rpl_status_regs (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .rx(rx), .parity_count_threshold(count_threshold),
      .parity_flag(parity_flag));
   rpl_serializer_model u_rpl_serializer_model (.go(go), .port(port), .val(val), .rx(rx));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge ref_clk);
      req.rd = 1'b0;
      chk("rvalid", {7'h00, rvalid_q}, 8'h01);
      chk($sformatf("read %h", a), rdata_q, exp);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge ref_clk);
      req.wr = 1'b0;
   endtask : wr
   task automatic send(input logic p, input rpl_rx_t v, input int n);
      @(negedge ref_clk);
      go = 1'b1;
      port = p;
      val = v;
      repeat (n) @(negedge ref_clk);
      go = 1'b0;
   endtask : send
   task automatic summarize();
      if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      s0 = '{8'h93, 8'h40, 1'b1, 1'b1, '{6'h2a, 3'h5, 3'h3, 3'h6, 5'h15}, 1'b0, 1'b0};
      s1 = '{8'h2c, 8'hc1, 1'b1, 1'b1, '{6'h15, 3'h2, 3'h4, 3'h1, 5'h0a}, 1'b0, 1'b0};
      e = '0;
      e.parity_err = 1'b1;
      lk = '0;
      lk.lock_acquired = 1'b1;
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      rd(RPL_OFS_PORT_SEL, RPL_RST_PSEL);
      rd(RPL_OFS_FREQ_FRAC, 8'h00);
      rd(RPL_OFS_PAR_LOWER, 8'h00);
      send(1'b0, s0, 1);
      send(1'b1, s1, 1);
      wr(RPL_OFS_ALARM, 8'hff);
      foreach (rows[i]) begin
         wr(RPL_OFS_PORT_SEL, rows[i].psel);
         rd(rows[i].addr, rows[i].exp);
      end
      wr(RPL_OFS_PORT_SEL, 8'h01);
      send(1'b0, e, 261);
      chk("flag", {6'h00, parity_flag}, 8'h01);
      // Errors stop before the counter bytes are read
      rd(RPL_OFS_PAR_UPPER, 8'h01);
      // Late errors between the two byte reads must not tear the pair
      send(1'b0, e, 2);
      rd(RPL_OFS_PAR_LOWER, 8'h05);
      rd(RPL_OFS_PAR_UPPER, 8'h00);
      chk("flag", {6'h00, parity_flag}, 8'h00);
      send(1'b0, e, 4);
      chk("flag", {6'h00, parity_flag}, 8'h01);
      send(1'b0, lk, 1);
      rd(RPL_OFS_PAR_UPPER, 8'h00);
      rd(RPL_OFS_PAR_LOWER, 8'h00);
      chk("flag", {6'h00, parity_flag}, 8'h00);
      // Port 1 errors; a lower-byte read on port 0 must leave port 1 alone
      send(1'b1, e, 5);
      chk("flag", {6'h00, parity_flag}, 8'h02);
      rd(RPL_OFS_PAR_LOWER, 8'h00);
      chk("flag", {6'h00, parity_flag}, 8'h02);
      wr(RPL_OFS_PORT_SEL, 8'h02);
      rd(RPL_OFS_PAR_LOWER, 8'h05);
      chk("flag", {6'h00, parity_flag}, 8'h00);
      // Mid-run reset returns the port select and port 0's copy to their reset state
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      rd(RPL_OFS_PORT_SEL, RPL_RST_PSEL);
      rd(RPL_OFS_FREQ_FRAC, RPL_RST_BYTE);
      summarize();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end
endmodule : rpl_status_regs_tb
